//--- hdl/bemf_event_detector.sv
/*
  Rotor position event detector: phase input selection, commutation /
  demagnetization / zero-crossing sequencing, spike filters, flags.
  Assumes the analog mux and hysteresis comparator sit outside and return
  a digital comparator level; timer, PWM and software bits arrive on core_clk.
*/
`timescale 1ns/100ps
`include "bemf_params.svh"

// What this block does
// - sensor mode select low gives sensorless operation, high gives sensor operation.
// - two-bit input select routes one phase input for codes 0 to 2 in both modes; code 3 routes none.
// - sensorless mode picks one of four comparator reference levels.
// - sensorless: zero-cross sampling uses window generator in current mode, PWM strobe in voltage.
// - end of demagnetization is sampled at a fixed 800 kHz rate.
// - events are accepted only in order commutation, demagnetization, zero crossing; sensor mode goes from commutation straight to zero crossing.
// - polarity and level bits classify edges as D or Z.
// - sensorless: demag edges ignored for 20 us after each commutation.
// - sensorless: zero crossings ignored for 20 us after each demag event.
// - hardware demag edge loads the step timer into demag time.
// - software demag fires when step timer equals demag time.
// - with both demag sources enabled, the first one gives the single event.
// - either demag source sets the demag flag; mask gates the request.
// - after C and D, PWM group may switch and Z sampling starts.
// - sense group bit picks odd or even high-side group for sensing.
// - gated zero crossing sets its flag and requests if its mask is set.
// - sensor mode: levels only, all demagnetization features disabled.
// - sensor mode: zero crossing taken in any window at 800 kHz sampling.
// - sensor mode: current PWM minimum off time is one 1.25 us period.
// - sensor mode: config top bit off, post-demag PWM only, 20 us Z filter.
module bemf_event_detector (
    input  wire logic       core_clk,
    input  wire logic       nrst,
    input  wire logic       phaseInputA,
    input  wire logic       phaseInputB,
    input  wire logic       phaseInputC,
    input  wire logic       compLevel,
    input  wire logic       sensorModeSelect,
    input  wire logic [1:0] inputSelect,
    input  wire logic [1:0] refVoltageSelect,
    input  wire logic [3:0] windowRateSelect,
    input  wire logic       currentMode,
    input  wire logic       pwmSampleStrobe,
    input  wire logic       edgePolaritySelect,
    input  wire logic       zeroLevelSelect,
    input  wire logic       hwDemagEnable,
    input  wire logic       swDemagEnable,
    input  wire logic [7:0] stepTimer,
    input  wire logic       commutationEvent,
    input  wire logic       demagTimeWrite,
    input  wire logic [7:0] demagTimeWdata,
    input  wire logic [2:0] pwmOutputConfig,
    input  wire logic       senseGroupSelect,
    input  wire logic       pwmOnOddGroup,
    input  wire logic       pwmOnEvenGroup,
    input  wire logic       demagIrqMask,
    input  wire logic       zeroCrossIrqMask,
    input  wire logic       demagFlagClear,
    input  wire logic       zeroCrossFlagClear,
    input  wire logic       latchStrobe,
    output logic      [1:0] analogMuxSelect,
    output logic      [1:0] compRefSelect,
    output logic      [7:0] demagTimeReg,
    output logic            demagFlag,
    output logic            zeroCrossFlag,
    output logic            demagIrq,
    output logic            zeroCrossIrq,
    output logic            demagEvent,
    output logic            zeroCrossEvent,
    output logic            pwmAfterDemag,
    output logic      [2:0] pwmConfigEff,
    output logic      [7:0] minOffCycles,
    output logic            comparatorState
);
    localparam logic [`FILTER_W-1:0] FILTER_LAST = `FILTER_W'(`FILTER_CYCLES - 1);
    localparam logic [7:0]           MINOFF_SENS = 8'(`MINOFF_SENSOR_CYC);
    localparam logic [7:0]           MINOFF_SLES = 8'(`MINOFF_SLESS_CYC);

    tick_if ticks ();

    logic [2:0]            phaseMeta_q;
    logic [2:0]            phaseSync_q;
    logic                  compMeta_q;
    logic                  compSync_q;
    logic                  selLevel;
    logic                  sample_q;
    logic                  samplePrev_q;
    logic                  sampleTick;
    logic                  zeroRising;
    logic                  zeroEdge;
    logic                  demagEdge;
    logic                  groupOk;
    logic                  hwDemag;
    logic                  swDemag;
    logic                  demagHit;
    logic                  zeroHit;
    logic                  filterBusy;
    logic [`FILTER_W-1:0]  filterCnt_q;
    logic                  filterRun_q;
    logic                  demagPulse_q;
    logic                  zeroPulse_q;
    bemf_pkg::detState_t   state_q;
    bemf_pkg::detState_t   state_d;

    // picks one of three synchronised phase levels
    function automatic logic pickPhase(input logic [2:0] lv, input logic [1:0] sel);
        logic r;
        r = 1'b0;
        unique case (sel)
            2'h0: r = lv[0];
            2'h1: r = lv[1];
            2'h2: r = lv[2];
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    sample_clock_gen u_ticks (
        .core_clk (core_clk),
        .nrst     (nrst),
        .ticks    (ticks.gen)
    );

    assign ticks.rateSel = windowRateSelect;

    // two-stage synchronisers; the first stage feeds only the second
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            phaseMeta_q <= 3'h0;
            phaseSync_q <= 3'h0;
            compMeta_q  <= 1'b0;
            compSync_q  <= 1'b0;
        end else begin
            phaseMeta_q <= {phaseInputC, phaseInputB, phaseInputA};
            phaseSync_q <= phaseMeta_q;
            compMeta_q  <= compLevel;
            compSync_q  <= compMeta_q;
        end
    end

    // sensor mode reads digital levels, sensorless reads the comparator
    assign selLevel = sensorModeSelect ? pickPhase(phaseSync_q, inputSelect)
                                       : compSync_q;

    // analog mux and reference choice handed to the front end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            analogMuxSelect <= 2'h0;
            compRefSelect   <= `REF_SEL_RESET;
        end else begin
            analogMuxSelect <= inputSelect;
            compRefSelect   <= refVoltageSelect;
        end
    end

    // group gate for back-EMF reading; config 3 reads either side
    always_comb begin
        if (pwmOutputConfig[1:0] == `OUTCFG_BOTH) begin
            groupOk = pwmOnOddGroup | pwmOnEvenGroup;
        end else if (senseGroupSelect) begin
            groupOk = pwmOnOddGroup;
        end else begin
            groupOk = pwmOnEvenGroup;
        end
    end

    // sample strobe: 800 kHz except sensorless Z, which uses window or PWM
    always_comb begin
        if (sensorModeSelect || state_q != bemf_pkg::WAIT_ZERO) begin
            sampleTick = ticks.tick800k;
        end else if (currentMode) begin
            sampleTick = ticks.windowTick & groupOk;
        end else begin
            sampleTick = pwmSampleStrobe & groupOk;
        end
    end

    // sampled level and its previous value form the edge detector
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sample_q     <= 1'b0;
            samplePrev_q <= 1'b0;
        end else if (sampleTick) begin
            sample_q     <= selLevel;
            samplePrev_q <= sample_q;
        end
    end

    // read-back level latches at 800 kHz and whenever the latch strobe is high
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            comparatorState <= 1'b0;
        end else if (ticks.tick800k || latchStrobe) begin
            comparatorState <= selLevel;
        end
    end

    // zero crossing edge direction; demag edge is the opposite swing
    assign zeroRising = edgePolaritySelect ^ zeroLevelSelect;
    assign zeroEdge   = zeroRising ? (sample_q & ~samplePrev_q)
                                   : (~sample_q & samplePrev_q);
    assign demagEdge  = zeroRising ? (~sample_q & samplePrev_q)
                                   : (sample_q & ~samplePrev_q);

    // demag sources are void in sensor mode
    assign hwDemag = ~sensorModeSelect & hwDemagEnable & demagEdge
                     & ~filterBusy;
    assign swDemag = ~sensorModeSelect & swDemagEnable
                     & (stepTimer == demagTimeReg);
    assign demagHit = (state_q == bemf_pkg::WAIT_DEMAG) & (hwDemag | swDemag);
    assign zeroHit  = (state_q == bemf_pkg::WAIT_ZERO) & zeroEdge
                      & ~filterBusy;

    // the filter counter is busy from a restart until it has run 20 us
    assign filterBusy = filterRun_q;

    // sequencer: commutation always restarts the cycle
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            bemf_pkg::WAIT_COMMUT: begin
                if (commutationEvent) begin
                    state_d = sensorModeSelect ? bemf_pkg::WAIT_ZERO
                                               : bemf_pkg::WAIT_DEMAG;
                end
            end
            bemf_pkg::WAIT_DEMAG: begin
                if (commutationEvent) begin
                    state_d = bemf_pkg::WAIT_DEMAG;
                end else if (demagHit) begin
                    state_d = bemf_pkg::WAIT_ZERO;
                end
            end
            bemf_pkg::WAIT_ZERO: begin
                if (commutationEvent) begin
                    state_d = sensorModeSelect ? bemf_pkg::WAIT_ZERO
                                               : bemf_pkg::WAIT_DEMAG;
                end else if (zeroHit) begin
                    state_d = bemf_pkg::WAIT_COMMUT;
                end
            end
            default: state_d = bemf_pkg::WAIT_COMMUT;
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= bemf_pkg::WAIT_COMMUT;
        end else begin
            state_q <= state_d;
        end
    end

    // 20 us blanking, restarted by commutation and by a demag event
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            filterCnt_q <= '0;
            filterRun_q <= 1'b0;
        end else if (commutationEvent) begin
            filterCnt_q <= '0;
            filterRun_q <= 1'b1;
        end else if (demagHit) begin
            filterCnt_q <= '0;
            filterRun_q <= 1'b1;
        end else if (filterRun_q) begin
            if (filterCnt_q == FILTER_LAST) begin
                filterRun_q <= 1'b0;
            end else begin
                filterCnt_q <= filterCnt_q + 1'b1;
            end
        end
    end

    // hardware capture beats a software write in the same cycle
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            demagTimeReg <= `DEMAG_TIME_RESET;
        end else if (hwDemag && state_q == bemf_pkg::WAIT_DEMAG) begin
            demagTimeReg <= stepTimer;
        end else if (demagTimeWrite) begin
            demagTimeReg <= demagTimeWdata;
        end
    end

    // event pulses, one core cycle each
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            demagPulse_q <= 1'b0;
            zeroPulse_q  <= 1'b0;
        end else begin
            demagPulse_q <= demagHit;
            zeroPulse_q  <= zeroHit;
        end
    end

    assign demagEvent     = demagPulse_q;
    assign zeroCrossEvent = zeroPulse_q;

    // sticky flags: an event in the clearing cycle keeps the flag set
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            demagFlag <= 1'b0;
        end else if (demagHit) begin
            demagFlag <= 1'b1;
        end else if (demagFlagClear) begin
            demagFlag <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            zeroCrossFlag <= 1'b0;
        end else if (zeroHit) begin
            zeroCrossFlag <= 1'b1;
        end else if (zeroCrossFlagClear) begin
            zeroCrossFlag <= 1'b0;
        end
    end

    // requests follow flag and mask without delay
    assign demagIrq     = demagFlag & demagIrqMask;
    assign zeroCrossIrq = zeroCrossFlag & zeroCrossIrqMask;

    // PWM hints: group switch after D, top config bit off in sensor mode
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pwmAfterDemag <= 1'b0;
            pwmConfigEff  <= 3'h0;
            minOffCycles  <= MINOFF_SLES;
        end else begin
            pwmAfterDemag <= sensorModeSelect | (state_d == bemf_pkg::WAIT_ZERO);
            pwmConfigEff  <= {pwmOutputConfig[2] & ~sensorModeSelect,
                              pwmOutputConfig[1:0]};
            minOffCycles  <= sensorModeSelect ? MINOFF_SENS : MINOFF_SLES;
        end
    end
endmodule

//--- hdl/bemf_params.svh
/*
  Timing counts and fixed values for the back-EMF event detector.
  Assumes a 40 MHz core clock; counts derive from it.
*/
`ifndef BEMF_PARAMS_SVH
`define BEMF_PARAMS_SVH

`define CORE_CLK_HZ        40000000
`define CORE_PERIOD_NS     25
`define SAMPLE_HZ          800000
`define SAMPLE_DIV         (`CORE_CLK_HZ / `SAMPLE_HZ)
`define FILTER_NS          20000
`define FILTER_CYCLES      ((`FILTER_NS + `CORE_PERIOD_NS - 1) / `CORE_PERIOD_NS)
`define MINOFF_SENSOR_NS   1250
`define MINOFF_SENSOR_CYC  ((`MINOFF_SENSOR_NS + `CORE_PERIOD_NS - 1) / `CORE_PERIOD_NS)
`define MINOFF_SLESS_CYC   100
`define FILTER_W           10
`define DIV_W              6
`define DEMAG_TIME_RESET   8'h00
`define REF_SEL_RESET      2'h0
`define OUTCFG_BOTH        2'h3

`endif

//--- hdl/bemf_pkg.sv
/*
  Types shared by the back-EMF detector files.
  Assumes nothing of its surroundings.
*/
package bemf_pkg;
    // one-hot event sequencer states: commutation, then demag, then zero cross
    typedef enum logic [2:0] {
        WAIT_COMMUT = 3'b001,
        WAIT_DEMAG  = 3'b010,
        WAIT_ZERO   = 3'b100
    } detState_t;
endpackage

//--- hdl/sample_clock_gen.sv
/*
  Divider making the 800 kHz sample enable and the measurement window enable.
  Assumes core_clk at 40 MHz and an active-low asynchronous reset.
*/
`timescale 1ns/100ps
`include "bemf_params.svh"
module sample_clock_gen (
    input wire logic core_clk,
    input wire logic nrst,
    tick_if.gen      ticks
);
    localparam logic [`DIV_W-1:0] DIV_LAST = `DIV_W'(`SAMPLE_DIV - 1);

    logic [`DIV_W-1:0] divCnt_q;
    logic [3:0]        winCnt_q;
    logic              tick_q;
    logic              win_q;

    // 800 kHz enable: one core cycle in every fifty
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            divCnt_q <= '0;
            tick_q   <= 1'b0;
        end else begin
            tick_q   <= (divCnt_q == DIV_LAST);
            divCnt_q <= (divCnt_q == DIV_LAST) ? '0 : divCnt_q + 1'b1;
        end
    end

    // window enable every (rateSel+1) sample ticks; a rate change acts at the next sample tick
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            winCnt_q <= 4'h0;
            win_q    <= 1'b0;
        end else begin
            win_q <= 1'b0;
            if (divCnt_q == DIV_LAST) begin
                if (winCnt_q >= ticks.rateSel) begin
                    winCnt_q <= 4'h0;
                    win_q    <= 1'b1;
                end else begin
                    winCnt_q <= winCnt_q + 4'h1;
                end
            end
        end
    end

    assign ticks.tick800k   = tick_q;
    assign ticks.windowTick = win_q;
endmodule

//--- hdl/tick_if.sv
/*
  Sample tick carrier between the divider and the detector core.
  Assumes a single core clock domain for both ends.
*/
`timescale 1ns/100ps
interface tick_if;
    logic       tick800k;
    logic       windowTick;
    logic [3:0] rateSel;
    modport gen (input rateSel, output tick800k, output windowTick);
    modport core (output rateSel, input tick800k, input windowTick);
endinterface

//--- tb/bemf_event_detector_sva.sv
/*
  Port checker bound to the detector top.
  Assumes one core clock, 800-cycle filters.
*/
`timescale 1ns/100ps
module bemf_event_detector_sva (
    input wire logic       core_clk,
    input wire logic       nrst,
    input wire logic [1:0] inputSelect,
    input wire logic [1:0] analogMuxSelect,
    input wire logic       sensorModeSelect,
    input wire logic       hwDemagEnable,
    input wire logic       swDemagEnable,
    input wire logic       commutationEvent,
    input wire logic [7:0] stepTimer,
    input wire logic [7:0] demagTimeReg,
    input wire logic       demagIrqMask,
    input wire logic       zeroCrossIrqMask,
    input wire logic       demagFlag,
    input wire logic       zeroCrossFlag,
    input wire logic       demagIrq,
    input wire logic       zeroCrossIrq,
    input wire logic       demagEvent,
    input wire logic       zeroCrossEvent,
    input wire logic [7:0] minOffCycles
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    logic [10:0] sinceC_q;
    logic [10:0] sinceD_q;
    logic        seenD_q;

    // saturating ages of last C and D; 11 bits outlast the filter
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sinceC_q <= 11'h000;
            sinceD_q <= 11'h000;
            seenD_q  <= 1'b0;
        end else begin
            sinceC_q <= commutationEvent ? 11'h000 : sinceC_q + {10'h000, ~&sinceC_q};
            sinceD_q <= demagEvent ? 11'h000 : sinceD_q + {10'h000, ~&sinceD_q};
            seenD_q  <= commutationEvent ? 1'b0 : (seenD_q | demagEvent);
        end
    end

    a_mux_select_follow: assert property ($past(nrst) |-> analogMuxSelect == $past(inputSelect))
        else $error("mux select lags");
    a_demag_irq_gate: assert property (demagIrq == (demagFlag && demagIrqMask))
        else $error("bad demag request");
    a_zero_irq_gate: assert property (zeroCrossIrq == (zeroCrossFlag && zeroCrossIrqMask))
        else $error("bad zero request");
    a_demag_sets_flag: assert property (demagEvent |-> demagFlag)
        else $error("demag event without flag");
    a_zero_after_demag: assert property (zeroCrossEvent && !sensorModeSelect |-> seenD_q)
        else $error("zero cross before demag");
    a_demag_filter_hw: assert property (demagEvent && !swDemagEnable |-> sinceC_q >= 11'd800)
        else $error("demag inside commutation filter");
    a_zero_filter_demag: assert property (zeroCrossEvent && !sensorModeSelect |-> sinceD_q >= 11'd800)
        else $error("zero cross inside demag filter");
    a_sensor_zero_filter: assert property (zeroCrossEvent && sensorModeSelect |-> sinceC_q >= 11'd800)
        else $error("sensor zero cross in filter");
    a_sensor_no_demag: assert property (sensorModeSelect && $past(sensorModeSelect) |-> !demagEvent)
        else $error("demag event in sensor mode");
    a_sensor_min_off: assert property (sensorModeSelect && $past(sensorModeSelect) && $past(nrst)
        |-> minOffCycles == 8'h32)
        else $error("sensor min off time wrong");
    a_hw_capture_time: assert property (demagEvent && hwDemagEnable && !swDemagEnable
        |-> demagTimeReg == $past(stepTimer))
        else $error("timer not captured");

    c_demag: cover property (demagEvent);
    c_zero_sensorless: cover property (zeroCrossEvent && !sensorModeSelect);
    c_zero_sensor: cover property (zeroCrossEvent && sensorModeSelect);
endmodule

bind bemf_event_detector bemf_event_detector_sva chk (.core_clk, .nrst, .inputSelect, .analogMuxSelect,
    .sensorModeSelect, .hwDemagEnable, .swDemagEnable, .commutationEvent, .stepTimer, .demagTimeReg,
    .demagIrqMask, .zeroCrossIrqMask, .demagFlag, .zeroCrossFlag, .demagIrq, .zeroCrossIrq, .demagEvent,
    .zeroCrossEvent, .minOffCycles);

//--- tb/bemf_event_detector_tb_top.sv
/*
  Self-checking bench with a winding model.
  Assumes 40 MHz core_clk and 800-cycle filters.
*/
`timescale 1ns/100ps
module bemf_event_detector_tb_top;
    typedef struct packed {logic [1:0] sel; logic [1:0] refSel; logic [2:0] wind; logic lvl;} row_t;
    logic core_clk = 1'b0, nrst = 1'b0, phaseInputA, phaseInputB, phaseInputC, compLevel;
    logic sensorModeSelect = 1'b0, currentMode = 1'b1, pwmSampleStrobe = 1'b0, edgePolaritySelect = 1'b1;
    logic zeroLevelSelect = 1'b0, hwDemagEnable = 1'b0, swDemagEnable = 1'b0, commutationEvent = 1'b0;
    logic demagTimeWrite = 1'b0, senseGroupSelect = 1'b0, pwmOnOddGroup = 1'b0, pwmOnEvenGroup = 1'b0;
    logic demagIrqMask = 1'b1, zeroCrossIrqMask = 1'b1, demagFlagClear = 1'b0, zeroCrossFlagClear = 1'b0;
    logic latchStrobe = 1'b0, timerRun = 1'b0;
    logic [1:0] inputSelect = 2'h0, refVoltageSelect = 2'h0, analogMuxSelect, compRefSelect;
    logic [2:0] windLevel = 3'h0, pwmOutputConfig = 3'h0, pwmConfigEff;
    logic [3:0] windowRateSelect = 4'h0;
    logic [7:0] stepTimer = 8'h00, demagTimeWdata = 8'h00, demagTimeReg, minOffCycles;
    logic demagFlag, zeroCrossFlag, demagIrq, zeroCrossIrq, demagEvent, zeroCrossEvent, pwmAfterDemag;
    logic comparatorState;
    int fail_count = 0, samples_checked = 0, dCnt = 0, zCnt = 0, dBase, zBase;
    row_t rows [6] = '{'{2'h0, 2'h0, 3'h1, 1'b1}, '{2'h1, 2'h1, 3'h1, 1'b0}, '{2'h1, 2'h2, 3'h2, 1'b1},
                       '{2'h2, 2'h3, 3'h4, 1'b1}, '{2'h2, 2'h0, 3'h3, 1'b0}, '{2'h3, 2'h1, 3'h7, 1'b0}};

    bemf_event_detector DUT (.core_clk, .nrst, .phaseInputA, .phaseInputB, .phaseInputC, .compLevel,
        .sensorModeSelect, .inputSelect, .refVoltageSelect, .windowRateSelect, .currentMode, .pwmSampleStrobe,
        .edgePolaritySelect, .zeroLevelSelect, .hwDemagEnable, .swDemagEnable, .stepTimer, .commutationEvent,
        .demagTimeWrite, .demagTimeWdata, .pwmOutputConfig, .senseGroupSelect, .pwmOnOddGroup, .pwmOnEvenGroup,
        .demagIrqMask, .zeroCrossIrqMask, .demagFlagClear, .zeroCrossFlagClear, .latchStrobe, .analogMuxSelect,
        .compRefSelect, .demagTimeReg, .demagFlag, .zeroCrossFlag, .demagIrq, .zeroCrossIrq, .demagEvent,
        .zeroCrossEvent, .pwmAfterDemag, .pwmConfigEff, .minOffCycles, .comparatorState);
    phase_winding_model WM (.windLevel, .analogMuxSelect, .phaseInputA, .phaseInputB, .phaseInputC, .compLevel);

    // clock: 25 ns period
    always #12.5 core_clk = ~core_clk;

    // step timer restarts at each commutation; voltage-mode strobe every 16 counts
    always @(posedge core_clk) begin
        if (commutationEvent) stepTimer <= 8'h00;
        else if (timerRun) stepTimer <= stepTimer + 8'h01;
        pwmSampleStrobe <= timerRun && (stepTimer[3:0] == 4'h0);
        if (demagEvent === 1'b1) dCnt <= dCnt + 1;
        if (zeroCrossEvent === 1'b1) zCnt <= zCnt + 1;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic commute();
        commutationEvent <= 1'b1;
        cyc(1);
        commutationEvent <= 1'b0;
        dBase = dCnt;
        zBase = zCnt;
    endtask

    task automatic do_reset();
        nrst <= 1'b0;
        cyc(10);
        nrst <= 1'b1;
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // watchdog: sequence needs about 5600 cycles
    initial begin
        cyc(20000);
        fail_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        conclude();
    end

    // table rows, then event sequences
    initial begin
        do_reset();
        foreach (rows[i]) begin
            inputSelect <= rows[i].sel;
            refVoltageSelect <= rows[i].refSel;
            windLevel <= rows[i].wind;
            cyc(120);
            chk(analogMuxSelect, rows[i].sel, "mux select");
            chk(compRefSelect, rows[i].refSel, "reference select");
            chk(comparatorState, rows[i].lvl, "sampled level");
        end
        chk(8'(dCnt + zCnt), 8'h00, "event before C");
        // soft demag, then voltage-mode Z on odd group
        inputSelect <= 2'h0;
        windLevel <= 3'h0;
        swDemagEnable <= 1'b1;
        currentMode <= 1'b0;
        pwmOutputConfig <= 3'h1;
        senseGroupSelect <= 1'b1;
        pwmOnOddGroup <= 1'b1;
        timerRun <= 1'b1;
        demagTimeWrite <= 1'b1;
        demagTimeWdata <= 8'h40; // above compare and timer
        cyc(1);
        demagTimeWrite <= 1'b0;
        cyc(119);
        commute();
        cyc(58);
        chk(8'(dCnt - dBase), 8'h00, "early soft demag");
        cyc(10);
        chk(8'(dCnt - dBase), 8'h01, "soft demag");
        chk(demagIrq, 1'b1, "demag request");
        cyc(130);
        windLevel <= 3'h1;
        cyc(200);
        windLevel <= 3'h0;
        cyc(480);
        chk(8'(zCnt - zBase), 8'h00, "Z in D filter");
        windLevel <= 3'h1;
        cyc(150);
        chk(8'(zCnt - zBase), 8'h01, "voltage mode zero cross");
        chk(zeroCrossIrq, 1'b1, "zero cross request");
        zeroCrossIrqMask <= 1'b0;
        cyc(2);
        chk(zeroCrossIrq, 1'b0, "masked zero cross request");
        zeroCrossFlagClear <= 1'b1;
        demagFlagClear <= 1'b1;
        cyc(1);
        zeroCrossFlagClear <= 1'b0;
        demagFlagClear <= 1'b0;
        cyc(2);
        chk({demagFlag, zeroCrossFlag}, 8'h00, "flags cleared");
        // hw demag: spike in filter, frozen timer captured
        swDemagEnable <= 1'b0;
        hwDemagEnable <= 1'b1;
        timerRun <= 1'b0;
        commute();
        cyc(1);
        stepTimer <= 8'h5a;
        cyc(296);
        windLevel <= 3'h0;
        cyc(200);
        windLevel <= 3'h1;
        cyc(490);
        chk(8'(dCnt - dBase), 8'h00, "D in C filter");
        chk(8'(zCnt - zBase), 8'h00, "zero cross before demag");
        windLevel <= 3'h0;
        cyc(150);
        chk(8'(dCnt - dBase), 8'h01, "hardware demag");
        chk(demagTimeReg, 8'h5a, "captured timer");
        // both sources: software masks first, hw edge ignored; current mode, even group
        swDemagEnable <= 1'b1;
        timerRun <= 1'b1;
        currentMode <= 1'b1;
        pwmOutputConfig <= 3'h0;
        senseGroupSelect <= 1'b0;
        pwmOnOddGroup <= 1'b0;
        commute();
        cyc(298);
        windLevel <= 3'h1;
        cyc(300);
        windLevel <= 3'h0;
        cyc(100);
        chk(8'(dCnt - dBase), 8'h01, "single demag event");
        cyc(400);
        windLevel <= 3'h1;
        cyc(200);
        chk(8'(zCnt - zBase), 8'h00, "zero cross off group");
        pwmOnEvenGroup <= 1'b1;
        cyc(150);
        chk(8'(zCnt - zBase), 8'h01, "current mode zero cross");
        // sensor mode after a second reset
        sensorModeSelect <= 1'b1;
        windLevel <= 3'h0;
        pwmOnEvenGroup <= 1'b0;
        pwmOutputConfig <= 3'h7;
        do_reset();
        cyc(3);
        chk(minOffCycles, 8'h32, "sensor min off");
        chk(pwmConfigEff, 3'h3, "config top bit");
        commute();
        cyc(298);
        windLevel <= 3'h1;
        cyc(200);
        windLevel <= 3'h0;
        cyc(490);
        chk(8'(zCnt - zBase), 8'h00, "sensor Z in filter");
        windLevel <= 3'h1;
        cyc(150);
        chk(8'(zCnt - zBase), 8'h01, "sensor zero cross");
        chk(8'(dCnt - dBase), 8'h00, "sensor demag");
        conclude();
    end
endmodule

//--- tb/phase_winding_model.sv
/*
  Model of the motor windings or position sensors on the phase pins, plus the
  external comparator level of the winding that the detector has muxed in.
  Assumes the bench sets winding levels off the clock edge.
*/
`timescale 1ns/100ps
module phase_winding_model (
    input  wire logic [2:0] windLevel,
    input  wire logic [1:0] analogMuxSelect,
    output logic            phaseInputA,
    output logic            phaseInputB,
    output logic            phaseInputC,
    output logic            compLevel
);
    // pins follow the windings; mux code 3 reaches no winding, so the comparator sees ground
    assign phaseInputA = windLevel[0];
    assign phaseInputB = windLevel[1];
    assign phaseInputC = windLevel[2];
    assign compLevel   = (analogMuxSelect == 2'h3) ? 1'b0 : windLevel[analogMuxSelect];
endmodule
